// ===== src/xcvr_pkg.sv
/*
 xcvr_pkg: shared constants, register map, field positions, timing counts and
 carrier types of the transceiver channel fabric-side logic.
 Assumes a single 20 MHz REF_CLK domain; every user of it imports xcvr_pkg::*.
*/
package xcvr_pkg;
	// clock and timing
	localparam int REF_CLK_PERIOD_NS = 50;
	localparam int PLL_CLEAR_MIN_NS = 1000;
	localparam int PLL_CLEAR_MIN_CYCLES = (PLL_CLEAR_MIN_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
	localparam int PLL_CLEAR_CNT_W = $clog2(PLL_CLEAR_MIN_CYCLES + 1);
	localparam int CANCEL_MAX_RECFG_CYCLES = 17000;
	localparam int DEF_LOCK_CYCLES = 64;
	localparam int DEF_TX_W = 8;
	localparam int RX_WORD_W = 16;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_RX_WORD = 8'h10;
	localparam logic [7:0] OFS_CANCEL_CNT = 8'h14;

	// control fields
	localparam int CTRL_PCIE_BIT = 0;
	localparam int CTRL_TEN_BIT = 1;
	localparam int CTRL_CANCEL_GO_BIT = 2;
	localparam logic [1:0] CTRL_RESET = 2'h0;

	// interrupt fields
	localparam int IRQ_W = 6;
	localparam int IRQ_LOCK = 0;
	localparam int IRQ_CANCEL_DONE = 1;
	localparam int IRQ_CODE_ERR = 2;
	localparam int IRQ_DISP_ERR = 3;
	localparam int IRQ_ORDER = 4;
	localparam int IRQ_SHORT_CLEAR = 5;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

	// receive word bit positions
	localparam int WB_CTRL = 8;
	localparam int WB_CODE_ERR = 9;
	localparam int WB_SYNC = 10;
	localparam int WB_DISP_ERR = 11;
	localparam int WB_PATTERN = 12;
	localparam int WB_RM_DEL = 13;
	localparam int WB_RM_INS = 14;
	localparam int WB_PIPE_LO = 13;
	localparam int WB_RUN_DISP = 15;

	// receive side flags from the channel datapath
	typedef struct packed {
		logic [9:0] symbol;
		logic [7:0] decoded;
		logic ctrl;
		logic code_err;
		logic sync;
		logic disp_err;
		logic pattern;
		logic rm_del;
		logic rm_ins;
		logic [1:0] pipe_status;
		logic run_disp;
		logic valid;
	} rx_flags_t;

	typedef enum logic [1:0] {
		TX_HELD = 2'b00,
		TX_CLEARING = 2'b01,
		TX_LOCKING = 2'b10,
		TX_RUNNING = 2'b11
	} tx_state_t;

	typedef enum logic [1:0] {
		OC_IDLE = 2'b00,
		OC_RUN = 2'b01,
		OC_DONE = 2'b10
	} oc_state_t;
endpackage : xcvr_pkg

// ===== src/lock_timer.sv
/*
 lock_timer: counts qualified steps while run is high, flags done at the limit.
 Assumes run and step are synchronous to clk; dropping run restarts the count.
*/
module lock_timer #(
	parameter int W = 8
) (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, active low
	input wire logic run, // count while high
	input wire logic step, // one step when high
	input wire logic [W-1:0] limit, // terminal count
	output logic [W-1:0] count, // current count
	output logic done // limit reached
);
	import xcvr_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} lt_state_t;

	lt_state_t st_q;
	lt_state_t st_d;

	// count up to the limit, then hold
	always_comb
	begin
		st_d = st_q;
		if (!run)
		begin
			st_d.cnt = '0;
			st_d.done = 1'b0;
		end
		else
		begin
			if (step && st_q.cnt != limit)
				st_d.cnt = st_q.cnt + W'(1);
			st_d.done = (st_d.cnt == limit);
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign count = st_q.cnt;
	assign done = st_q.done;
endmodule : lock_timer

// ===== src/rx_word_pack.sv
/*
 rx_word_pack: arranges decoded or raw receive data and status into the full
 receive word, registered. Assumes mode inputs are stable between words.
*/
module rx_word_pack (
	input wire logic clk, // clock
	input wire logic rst_n, // async reset, active low
	input xcvr_pkg::rx_flags_t flags, // channel flags
	input wire logic pcie_mode, // pcie functional mode
	input wire logic ten_bit, // 10-bit interface
	output logic [xcvr_pkg::RX_WORD_W-1:0] word, // full receive word
	output logic word_valid // word strobe
);
	import xcvr_pkg::*;

	typedef struct packed {
		logic [RX_WORD_W-1:0] word;
		logic valid;
	} pk_state_t;

	pk_state_t st_q;
	pk_state_t st_d;

	function automatic logic [RX_WORD_W-1:0] pack(rx_flags_t f, logic pcie, logic ten);
		logic [RX_WORD_W-1:0] w;
		w = '0;
		if (ten)
			w[9:0] = f.symbol;
		else
		begin
			w[7:0] = f.decoded;
			w[WB_CTRL] = f.ctrl;
			w[WB_CODE_ERR] = f.code_err;
		end
		w[WB_SYNC] = f.sync;
		w[WB_DISP_ERR] = f.disp_err;
		w[WB_PATTERN] = f.pattern;
		if (pcie)
			w[WB_PIPE_LO+1:WB_PIPE_LO] = f.pipe_status;
		else
		begin
			w[WB_RM_DEL] = f.rm_del;
			w[WB_RM_INS] = f.rm_ins;
		end
		w[WB_RUN_DISP] = f.run_disp;
		return w;
	endfunction : pack

	// capture a word each valid cycle
	always_comb
	begin
		st_d = st_q;
		st_d.valid = flags.valid;
		if (flags.valid)
			st_d.word = pack(flags, pcie_mode, ten_bit);
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign word = st_q.word;
	assign word_valid = st_q.valid;
endmodule : rx_word_pack

// ===== src/xcvr_channel.sv
/*
 xcvr_channel: fabric-side logic of one transceiver channel. Tracks the
 transmit-only reset sequence, models PLL lock acquisition, gates transmit data,
 runs receiver offset cancellation, packs the full receive word, and offers a
 small register file with sticky interrupts.
 Assumes all inputs synchronous to REF_CLK, the reconfiguration clock sampled
 as a plain input, and a register master that never issues read and write
 together. PLL lock is a counter model that only starts after a seen clear
 pulse; the lock flag is synchronous to REF_CLK and the user must still
 synchronise it before use. Cancellation counts reconfiguration clock rises
 from its first (idle) cycle on, so its bound holds from the request onward.
 Protocol slips by the user are flagged as interrupt events, never blocked,
 except that transmit data outside the running state is dropped.
*/
// How it works
// - after PLL clear release the PLL starts acquiring lock
// - after lock and transmit reset release the transmitter accepts and sends data
// - 8-bit mode: decoded byte bits 7:0, control flag 8, code violation 9
// - bits 10, 11, 12 carry alignment, disparity error, pattern detect
// - outside PCIe: bit 13 rate-match deletion, bit 14 insertion
// - PCIe mode: bits 14:13 carry receive status code
// - bit 15 carries current running disparity
// - 10-bit mode: raw symbol on bits 9:0, bits 10-12 as before
// - offset cancellation finishes within 17000 reconfiguration clock cycles
module xcvr_channel #(
	// REF_CLK cycles from clear release to lock
	parameter int LOCK_CYCLES = xcvr_pkg::DEF_LOCK_CYCLES,
	// reconfiguration clock rises that one cancellation takes
	parameter int CANCEL_CYCLES = xcvr_pkg::CANCEL_MAX_RECFG_CYCLES,
	// transmit word width
	parameter int TX_W = xcvr_pkg::DEF_TX_W
) (
	input wire logic REF_CLK, // 20 MHz clock
	input wire logic RESET_N, // async reset, active low
	input wire logic RECONFIGURATION_CLOCK, // sampled reconfiguration clock
	input wire logic PLL_CLEAR, // PLL clear from user logic
	input wire logic TX_LOGIC_RESET, // transmit logic reset from user
	input wire logic [TX_W-1:0] TX_DATA, // transmit data
	input wire logic TX_DATA_VALID, // transmit data strobe
	input xcvr_pkg::rx_flags_t RX_IN, // receive datapath flags
	input wire logic [7:0] ADDR, // register byte address
	input wire logic [31:0] WDATA, // register write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [31:0] RDATA, // read data, cycle after RD
	output logic IRQ, // interrupt, active high level
	output logic PLL_LOCKED, // PLL lock flag
	output logic TX_READY, // transmitter accepting data
	output logic [TX_W-1:0] TX_WORD, // accepted transmit word
	output logic TX_WORD_VALID, // transmit word strobe
	output logic [xcvr_pkg::RX_WORD_W-1:0] RX_WORD, // full receive word
	output logic RX_WORD_VALID, // receive word strobe
	output logic CANCEL_DONE // offset cancellation finished
);
	import xcvr_pkg::*;

	// counter widths of the lock and cancellation timers
	localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
	localparam int CAN_W = $clog2(CANCEL_CYCLES + 1);

	// every register of the block except those in the timers and the packer, in one word
	typedef struct packed {
		tx_state_t tx;
		oc_state_t oc;
		logic [1:0] ctrl;
		logic [IRQ_W-1:0] irq;
		logic [IRQ_W-1:0] mask;
		logic [31:0] rdata;
		logic irq_out;
		logic pll_locked;
		logic tx_ready;
		logic [TX_W-1:0] tx_word;
		logic tx_valid;
		logic recfg_prev;
		logic [PLL_CLEAR_CNT_W-1:0] clear_cnt;
		logic [RX_WORD_W-1:0] rx_snap;
		logic cancel_done;
	} st_t;

	// whole-block state and its next value
	st_t st_q;
	st_t st_d;

	// glue between the timers, the packer and the state update
	logic lock_run;
	logic lock_done;
	logic oc_run;
	logic oc_step;
	logic oc_done;
	logic [CAN_W-1:0] oc_count;
	logic [RX_WORD_W-1:0] rx_word;
	logic rx_word_valid;
	logic [IRQ_W-1:0] ev;
	logic cancel_go;
	logic [IRQ_W-1:0] irq_clr;

	// low-to-high step between the previous and the current sample
	function automatic logic rose_now(logic now_v, logic last_v);
		return now_v && !last_v;
	endfunction : rose_now

	// write strobe aimed at one register offset
	function automatic logic wr_hit(logic wr_s, logic [7:0] a, logic [7:0] ofs);
		return wr_s && (a == ofs);
	endfunction : wr_hit

	// sticky status: write one to clear, a new event in the same cycle wins
	function automatic logic [IRQ_W-1:0] w1c(logic [IRQ_W-1:0] old_v, logic [IRQ_W-1:0] clr_v,
		logic [IRQ_W-1:0] set_v);
		return (old_v & ~clr_v) | set_v;
	endfunction : w1c

	// status image: lock, ready, done, then transmit and cancellation state codes
	function automatic logic [31:0] status_image(st_t s);
		return {25'h0, s.oc, s.tx, s.cancel_done, s.tx_ready, s.pll_locked};
	endfunction : status_image

	// PLL only acquires once its clear has been seen and released
	assign lock_run = (st_q.tx == TX_LOCKING || st_q.tx == TX_RUNNING) && !PLL_CLEAR;

	lock_timer #(
		.W(LOCK_W)
	) u_pll_lock (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.run(lock_run),
		.step(1'b1),
		.limit(LOCK_W'(LOCK_CYCLES)),
		.count(),
		.done(lock_done)
	);

	// cancellation counts reconfiguration clock rises from its idle cycle on
	assign oc_run = (st_q.oc != OC_DONE);
	assign oc_step = rose_now(RECONFIGURATION_CLOCK, st_q.recfg_prev);

	lock_timer #(
		.W(CAN_W)
	) u_offset_cancel (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.run(oc_run),
		.step(oc_step),
		.limit(CAN_W'(CANCEL_CYCLES)),
		.count(oc_count),
		.done(oc_done)
	);

	rx_word_pack u_rx_pack (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.flags(RX_IN),
		.pcie_mode(st_q.ctrl[CTRL_PCIE_BIT]),
		.ten_bit(st_q.ctrl[CTRL_TEN_BIT]),
		.word(rx_word),
		.word_valid(rx_word_valid)
	);

	// restart request and write-one-to-clear mask from the register port
	assign cancel_go = wr_hit(WR, ADDR, OFS_CTRL) && WDATA[CTRL_CANCEL_GO_BIT];
	assign irq_clr = wr_hit(WR, ADDR, OFS_IRQ_STATUS) ? WDATA[IRQ_W-1:0] : '0;

	// next state of the whole block
	always_comb
	begin
		// hold by default; strobes and events last one cycle
		st_d = st_q;
		ev = '0;
		st_d.recfg_prev = RECONFIGURATION_CLOCK;
		st_d.pll_locked = lock_done;
		st_d.tx_valid = 1'b0;

		// rising lock flag is an event
		if (rose_now(lock_done, st_q.pll_locked))
			ev[IRQ_LOCK] = 1'b1;

		// transmit-only reset sequence tracking
		unique case (st_q.tx)
			// held: wait for the user to raise the PLL clear
			TX_HELD:
			begin
				st_d.clear_cnt = '0;
				if (PLL_CLEAR)
					st_d.tx = TX_CLEARING;
			end
			// clearing: time the pulse, transmit reset must stay high
			TX_CLEARING:
			begin
				if (st_q.clear_cnt != PLL_CLEAR_CNT_W'(PLL_CLEAR_MIN_CYCLES))
					st_d.clear_cnt = st_q.clear_cnt + PLL_CLEAR_CNT_W'(1);
				if (!TX_LOGIC_RESET)
					ev[IRQ_ORDER] = 1'b1;
				if (!PLL_CLEAR)
				begin
					if (st_q.clear_cnt < PLL_CLEAR_CNT_W'(PLL_CLEAR_MIN_CYCLES))
						ev[IRQ_SHORT_CLEAR] = 1'b1;
					st_d.tx = TX_LOCKING;
				end
			end
			// locking: PLL acquires, transmit reset may drop only after lock
			TX_LOCKING:
			begin
				if (PLL_CLEAR)
				begin
					st_d.clear_cnt = '0;
					st_d.tx = TX_CLEARING;
				end
				else if (!TX_LOGIC_RESET && st_q.pll_locked)
					st_d.tx = TX_RUNNING;
				else if (!TX_LOGIC_RESET)
					ev[IRQ_ORDER] = 1'b1;
			end
			// running: accept one word per strobe
			TX_RUNNING:
			begin
				if (PLL_CLEAR)
				begin
					st_d.clear_cnt = '0;
					st_d.tx = TX_CLEARING;
				end
				else if (TX_LOGIC_RESET || !st_q.pll_locked)
					st_d.tx = TX_LOCKING;
				else if (TX_DATA_VALID)
				begin
					st_d.tx_word = TX_DATA;
					st_d.tx_valid = 1'b1;
				end
			end
		endcase
		st_d.tx_ready = (st_d.tx == TX_RUNNING);

		// offset cancellation runs after reset and on request
		unique case (st_q.oc)
			// idle: one cycle, already counting
			OC_IDLE:
				st_d.oc = OC_RUN;
			// run: wait for the step count to reach its limit
			OC_RUN:
			begin
				if (oc_done)
				begin
					st_d.oc = OC_DONE;
					ev[IRQ_CANCEL_DONE] = 1'b1;
				end
			end
			// done: stay until software asks for another pass
			OC_DONE:
			begin
				if (cancel_go)
					st_d.oc = OC_IDLE;
			end
			default:
				st_d.oc = OC_IDLE;
		endcase
		st_d.cancel_done = (st_d.oc == OC_DONE);

		// receive error events from the channel flags
		if (RX_IN.valid && !st_q.ctrl[CTRL_TEN_BIT] && RX_IN.code_err)
			ev[IRQ_CODE_ERR] = 1'b1;
		if (RX_IN.valid && RX_IN.disp_err)
			ev[IRQ_DISP_ERR] = 1'b1;
		// keep the last packed word for the register port
		if (rx_word_valid)
			st_d.rx_snap = rx_word;

		// register writes
		if (WR)
		begin
			unique case (ADDR)
				OFS_CTRL:
				begin
					// mode bits only; the restart bit is a strobe
					st_d.ctrl[CTRL_PCIE_BIT] = WDATA[CTRL_PCIE_BIT];
					st_d.ctrl[CTRL_TEN_BIT] = WDATA[CTRL_TEN_BIT];
				end
				OFS_IRQ_MASK:
					st_d.mask = WDATA[IRQ_W-1:0];
				default:
					st_d.mask = st_q.mask;
			endcase
		end

		// sticky status, write one to clear, new event wins
		st_d.irq = w1c(st_q.irq, irq_clr, ev);
		st_d.irq_out = |(st_d.irq & st_d.mask);

		// register reads, answer in the next cycle only
		st_d.rdata = 32'h0000_0000;
		if (RD)
		begin
			unique case (ADDR)
				OFS_CTRL:
					st_d.rdata = {30'h0, st_q.ctrl};
				OFS_STATUS:
					st_d.rdata = status_image(st_q);
				OFS_IRQ_STATUS:
					st_d.rdata = {26'h0, st_q.irq};
				OFS_IRQ_MASK:
					st_d.rdata = {26'h0, st_q.mask};
				OFS_RX_WORD:
					st_d.rdata = {16'h0, st_q.rx_snap};
				OFS_CANCEL_CNT:
					st_d.rdata = 32'(oc_count);
				default:
					st_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// state register
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			// all zero, then the named reset values
			st_q <= '0;
			st_q.tx <= TX_HELD;
			st_q.oc <= OC_IDLE;
			st_q.ctrl <= CTRL_RESET;
			st_q.mask <= IRQ_MASK_RESET;
		end
		else
			st_q <= st_d;
	end

	// register port and interrupt, straight from flip-flops
	assign RDATA = st_q.rdata;
	assign IRQ = st_q.irq_out;

	// reset sequence and transmit side
	assign PLL_LOCKED = st_q.pll_locked;
	assign TX_READY = st_q.tx_ready;
	assign TX_WORD = st_q.tx_word;
	assign TX_WORD_VALID = st_q.tx_valid;

	// receive side and cancellation; the packer registers the word
	assign RX_WORD = rx_word;
	assign RX_WORD_VALID = rx_word_valid;
	assign CANCEL_DONE = st_q.cancel_done;
endmodule : xcvr_channel

// ===== dv/user_reset_ctl.sv
/*
 user_reset_ctl: user logic that runs the transmit-only reset order.
 assumes one fabric clock; the lock flag is synchronised before use.
*/
module user_reset_ctl
(
	input wire logic clk, // fabric clock
	input wire logic rst_n, // power-up reset
	input wire logic locked, // PLL lock flag
	output logic pll_clear, // PLL clear
	output logic tx_rst // transmit logic reset
);
	timeunit 1ns;
	timeprecision 1ns;
	import xcvr_pkg::*;
	logic [5:0] cnt_q;
	logic [1:0] sync_q;
	// hold clear past the minimum, free tx reset on synced lock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_q <= 6'h00;
			pll_clear <= 1'b1;
			tx_rst <= 1'b1;
			sync_q <= 2'h0;
		end
		else
		begin
			sync_q <= {sync_q[0], locked};
			if (cnt_q < 6'(PLL_CLEAR_MIN_CYCLES + 2))
				cnt_q <= cnt_q + 6'h01;
			else
				pll_clear <= 1'b0;
			if (!pll_clear && sync_q[1])
				tx_rst <= 1'b0;
		end
	end
endmodule : user_reset_ctl

// ===== dv/xcvr_channel_props.sv
/*
 xcvr_channel_props: port checks of the channel block.
 assumes mode is only set through the control register.
*/
module xcvr_channel_props #(
	parameter int LOCK_CYCLES = xcvr_pkg::DEF_LOCK_CYCLES,
	parameter int CANCEL_CYCLES = xcvr_pkg::CANCEL_MAX_RECFG_CYCLES,
	parameter int TX_W = xcvr_pkg::DEF_TX_W
) (
	input wire logic REF_CLK, // clock
	input wire logic RESET_N, // reset
	input wire logic RECONFIGURATION_CLOCK, // step clock
	input wire logic PLL_CLEAR, // clear
	input wire logic TX_LOGIC_RESET, // tx reset
	input wire logic [TX_W-1:0] TX_DATA, // tx data
	input wire logic TX_DATA_VALID, // tx strobe
	input xcvr_pkg::rx_flags_t RX_IN, // rx flags
	input wire logic [7:0] ADDR, // address
	input wire logic [31:0] WDATA, // write data
	input wire logic WR, // write
	input wire logic PLL_LOCKED, // lock
	input wire logic TX_READY, // ready
	input wire logic [TX_W-1:0] TX_WORD, // tx word
	input wire logic TX_WORD_VALID, // tx valid
	input wire logic [xcvr_pkg::RX_WORD_W-1:0] RX_WORD, // rx word
	input wire logic RX_WORD_VALID, // rx valid
	input wire logic CANCEL_DONE // done
);
	timeunit 1ns;
	timeprecision 1ns;
	import xcvr_pkg::*;
	localparam int LOCK_MAX = LOCK_CYCLES + 4;
	logic pcie_q, ten_q, rc_q;
	logic [15:0] steps_q;
	// mode shadow and step count of the running cancellation
	always_ff @(posedge REF_CLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			{pcie_q, ten_q, rc_q} <= 3'h0;
			steps_q <= 16'h0000;
		end
		else
		begin
			rc_q <= RECONFIGURATION_CLOCK;
			if (WR && ADDR == OFS_CTRL)
				{ten_q, pcie_q} <= WDATA[1:0];
			if (CANCEL_DONE)
				steps_q <= 16'h0000;
			else if (RECONFIGURATION_CLOCK && !rc_q)
				steps_q <= steps_q + 16'h0001;
		end
	end
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);
	a_rx_strobe: assert property (RX_IN.valid |=> RX_WORD_VALID) else $error("rx strobe missing");
	a_rx_byte_map: assert property (RX_IN.valid && !ten_q |=> RX_WORD[9:0] ==
		{$past(RX_IN.code_err), $past(RX_IN.ctrl), $past(RX_IN.decoded)}) else $error("byte field wrong");
	a_rx_status_bits: assert property (RX_IN.valid |=> RX_WORD[12:10] ==
		$past({RX_IN.pattern, RX_IN.disp_err, RX_IN.sync})) else $error("status bits wrong");
	a_rx_rate_match: assert property (RX_IN.valid && !pcie_q |=> RX_WORD[14:13] ==
		$past({RX_IN.rm_ins, RX_IN.rm_del})) else $error("rate match bits wrong");
	a_rx_pipe_code: assert property (RX_IN.valid && pcie_q |=>
		RX_WORD[14:13] == $past(RX_IN.pipe_status)) else $error("pipe status wrong");
	a_rx_run_disp: assert property (RX_IN.valid |=> RX_WORD[15] == $past(RX_IN.run_disp))
		else $error("disparity bit wrong");
	a_rx_raw_symbol: assert property (RX_IN.valid && ten_q |=> RX_WORD[9:0] == $past(RX_IN.symbol))
		else $error("raw symbol wrong");
	a_lock_after_clear: assert property ($fell(PLL_CLEAR) |-> ##[1:LOCK_MAX] PLL_LOCKED)
		else $error("no lock after clear");
	a_tx_accept: assert property (TX_DATA_VALID && TX_READY && !TX_LOGIC_RESET && !PLL_CLEAR
		|=> TX_WORD_VALID && TX_WORD == $past(TX_DATA)) else $error("tx word lost");
	a_tx_held_off: assert property (!TX_READY |=> !TX_WORD_VALID) else $error("tx word while held");
	a_cancel_bound: assert property (steps_q <= 16'(CANCEL_CYCLES)) else $error("cancel too long");
	c_lock: cover property ($rose(PLL_LOCKED));
	c_tx: cover property (TX_WORD_VALID ##1 TX_WORD_VALID);
	c_pcie: cover property (RX_IN.valid && pcie_q && ten_q);
	c_done: cover property ($rose(CANCEL_DONE));
endmodule : xcvr_channel_props

bind xcvr_channel xcvr_channel_props #(.LOCK_CYCLES(LOCK_CYCLES), .CANCEL_CYCLES(CANCEL_CYCLES), .TX_W(TX_W))
	u_props (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .RECONFIGURATION_CLOCK(RECONFIGURATION_CLOCK),
	.PLL_CLEAR(PLL_CLEAR), .TX_LOGIC_RESET(TX_LOGIC_RESET), .TX_DATA(TX_DATA), .TX_DATA_VALID(TX_DATA_VALID),
	.RX_IN(RX_IN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .PLL_LOCKED(PLL_LOCKED), .TX_READY(TX_READY),
	.TX_WORD(TX_WORD), .TX_WORD_VALID(TX_WORD_VALID), .RX_WORD(RX_WORD), .RX_WORD_VALID(RX_WORD_VALID),
	.CANCEL_DONE(CANCEL_DONE));

// ===== dv/xcvr_channel_tb.sv
/*
 xcvr_channel_tb: self-checking bench of the channel block.
 assumes the user reset model runs clear and tx reset; short counts set.
*/
module xcvr_channel_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import xcvr_pkg::*;
	logic ref_clk, reset_n, rcfg, pll_clear, tx_rst, tx_valid, wr, rd;
	logic irq, locked, tx_ready, tx_wvalid, rx_wvalid, cdone;
	logic [7:0] tx_data, tx_word, addr;
	logic [31:0] wdata, rdata, d;
	logic [15:0] rx_word;
	logic [1:0] rdiv;
	rx_flags_t rx_in;
	int fail_count, n_tests;
	user_reset_ctl u_user (.clk(ref_clk), .rst_n(reset_n), .locked(locked), .pll_clear(pll_clear),
		.tx_rst(tx_rst));
	xcvr_channel #(.LOCK_CYCLES(4), .CANCEL_CYCLES(8), .TX_W(8)) u_dut (.REF_CLK(ref_clk),
		.RESET_N(reset_n), .RECONFIGURATION_CLOCK(rcfg), .PLL_CLEAR(pll_clear), .TX_LOGIC_RESET(tx_rst),
		.TX_DATA(tx_data), .TX_DATA_VALID(tx_valid), .RX_IN(rx_in), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .IRQ(irq), .PLL_LOCKED(locked), .TX_READY(tx_ready), .TX_WORD(tx_word),
		.TX_WORD_VALID(tx_wvalid), .RX_WORD(rx_word), .RX_WORD_VALID(rx_wvalid), .CANCEL_DONE(cdone));
	// 20 MHz clock
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// slow step clock, one rise every 8 cycles
	always @(posedge ref_clk)
	begin
		if (!reset_n)
			{rdiv, rcfg} <= 3'h0;
		else
		begin
			rdiv <= rdiv + 2'h1;
			if (rdiv == 2'h3)
				rcfg <= ~rcfg;
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic wait_on(input int sel, input logic lvl);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge ref_clk);
			#1;
			if ((sel == 0 ? locked : sel == 1 ? tx_ready : cdone) === lvl)
				return;
		end
		fail_count++;
		$display("mismatch at %0t: wait %0d ran out", $time, sel);
		close_out();
	endtask : wait_on
	task automatic t_reset_seq();
		@(posedge ref_clk);
		tx_data <= 8'h77;
		tx_valid <= 1'b1;
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		#1 chk(tx_wvalid, 1'b0);
		wait_on(0, 1'b1);
		wait_on(1, 1'b1);
		rd_reg(OFS_STATUS, d);
		chk(d & 32'h1b, 32'h1b);
		rd_reg(OFS_IRQ_STATUS, d);
		chk(d & 32'h31, 32'h01);
		$display("reset sequence test done");
	endtask : t_reset_seq
	task automatic t_tx();
		@(posedge ref_clk);
		tx_data <= 8'ha5;
		tx_valid <= 1'b1;
		@(posedge ref_clk);
		tx_data <= 8'h3c;
		#1 chk({tx_wvalid, tx_word}, 9'h1a5);
		@(posedge ref_clk);
		tx_valid <= 1'b0;
		#1 chk({tx_wvalid, tx_word}, 9'h13c);
		$display("transmit test done");
	endtask : t_tx
	task automatic t_rx();
		rx_flags_t f;
		logic [15:0] e;
		for (int m = 0; m < 4; m++)
		begin
			f = '0;
			{f.symbol, f.decoded, f.ctrl, f.code_err} = {10'h2a5 ^ 10'(m), 8'h5c, 1'b1, m[0]};
			{f.sync, f.disp_err, f.pattern, f.rm_del, f.rm_ins} = {1'b1, m[1], 1'b1, 1'b1, m[0]};
			{f.pipe_status, f.run_disp, f.valid} = {2'(m + 1), 1'b1, 1'b1};
			wr_reg(OFS_CTRL, 32'(m));
			@(posedge ref_clk);
			rx_in <= f;
			@(posedge ref_clk);
			rx_in.valid <= 1'b0;
			e = {f.run_disp, m[0] ? f.pipe_status : {f.rm_ins, f.rm_del}, f.pattern, f.disp_err, f.sync,
				m[1] ? f.symbol : {f.code_err, f.ctrl, f.decoded}};
			#1 chk({rx_wvalid, rx_word}, {1'b1, e});
			rd_reg(OFS_RX_WORD, d);
			chk(d, 32'(e));
		end
		wr_reg(OFS_CTRL, 32'h0);
		$display("receive word test done");
	endtask : t_rx
	task automatic t_cancel();
		wait_on(2, 1'b1);
		wr_reg(OFS_IRQ_STATUS, 32'h2);
		wr_reg(OFS_CTRL, 32'h4);
		wait_on(2, 1'b0);
		rd_reg(OFS_STATUS, d);
		chk(d[6:2], 5'h0e);
		wait_on(2, 1'b1);
		chk(cdone, 1'b1);
		rd_reg(OFS_IRQ_STATUS, d);
		chk(d[1], 1'b1);
		$display("cancellation test done");
	endtask : t_cancel
	task automatic t_irq();
		rd_reg(OFS_IRQ_MASK, d);
		chk(d, 32'(IRQ_MASK_RESET));
		rd_reg(OFS_IRQ_STATUS, d);
		chk(d[5:0], 6'h0f);
		wr_reg(OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq, 1'b1);
		wr_reg(OFS_IRQ_STATUS, 32'h2);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq, 1'b0);
		rd_reg(OFS_IRQ_STATUS, d);
		chk(d[1], 1'b0);
		wr_reg(OFS_IRQ_MASK, 32'h0);
		rd_reg(8'h1c, d);
		chk(d, 32'h0);
		$display("interrupt test done");
	endtask : t_irq
	// reset, then the scenarios in turn
	initial
	begin
		{reset_n, tx_valid, wr, rd} = '0;
		{tx_data, addr, wdata} = '0;
		rx_in = '0;
		fail_count = 0;
		n_tests = 0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_reset_seq();
		t_tx();
		t_rx();
		t_cancel();
		t_irq();
		close_out();
	end
endmodule : xcvr_channel_tb
